// ---- shared/sbm_pkg.sv ----
// Package of constants and types for the status byte and macro runner
package sbm_pkg;
    // Status bit positions
    localparam int BIT_MACRO_DONE = 0;
    localparam int BIT_LIMIT = 1;
    localparam int BIT_SRQ_CMD = 2;
    localparam int BIT_POWER_ON = 3;
    localparam int BIT_READY = 4;
    localparam int BIT_ERROR = 5;
    localparam int BIT_SERVICE = 6;
    localparam int BIT_DATA_AVAIL = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // Free memory needed before macro entry may begin, in bytes
    localparam int MACRO_MIN_FREE = 800;
    // Integer names 0..127 map to slots; slot 0 is the autostart macro
    localparam int NUM_SLOTS = 128;
    localparam int SLOT_W = 7;
    localparam int MEM_DEPTH = 1024;
    localparam int PTR_W = 10;
    localparam int LEN_W = 11;
    localparam int FREE_W = 16;

    // Command opcodes as decoded by the host command parser
    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_OTHER,
        CMD_BEGIN_MACRO,
        CMD_END_MACRO,
        CMD_INVOKE,
        CMD_PAUSE,
        CMD_RESUME,
        CMD_ERASE_ALL,
        CMD_DELETE_MACRO,
        CMD_DEVICE_CLEAR,
        CMD_RESET,
        CMD_ARM_EXT,
        CMD_SINGLE_SHOT,
        CMD_ARM_OTHER,
        CMD_COMPRESS
    } sbm_cmd_e;

    typedef struct packed {
        sbm_cmd_e op;
        logic [SLOT_W-1:0] slot;
        logic [11:0] arg;
    } sbm_cmd_s;

    typedef enum {
        ST_IDLE,
        ST_ENTRY,
        ST_RUN,
        ST_PAUSED,
        ST_WAIT_SHOT,
        ST_WAIT_EXT
    } sbm_state_e;
endpackage

// ---- design/sbm_core.sv ----
// Status byte and stored-command macro runner
// Functional notes
// RULE1 - Status query returns the weighted sum of all set status bits.
// RULE2 - Bits 0..3: macro done, limit exceeded, service command, power on.
// RULE3 - Bit 4 ready, bit 5 error recorded, bit 7 output data available.
// RULE4 - Bit 6 is service requested and cannot be masked off.
// RULE5 - A condition sets its status bit, which stays set until cleared.
// RULE6 - Ready bit reads clear in the value returned by the status query.
// RULE7 - Clear command clears all bits; 4, 5, 6 stay while causes persist.
// RULE8 - Service mask chooses which conditions assert the bus service request.
// RULE9 - Host names macros up to 10 characters, or integer 0 to 127. Only integer slots 0 to 127 are modelled here.
// RULE10 - Integer names get a fixed prefix; bare or prefixed form both accepted.
// RULE11 - End command closes entry; invoke runs, pause suspends, resume continues.
// RULE12 - Storing under an existing name replaces the old macro completely.
// RULE13 - During entry erase-all, delete, nested begin and device clear are not stored.
// RULE14 - A reset command inside a running macro aborts execution.
// RULE15 - Macro entry refused when fewer than 800 bytes remain free.
// RULE16 - Any error detected during execution aborts the macro.
// RULE17 - Device clear aborts execution and also aborts macro entry.
// RULE18 - Single-shot command stalls the macro until all readings are taken.
// RULE19 - Other arm settings apply, readings held off until the macro finishes.
// RULE20 - External-arm command stalls the macro until an external trigger edge.
// RULE21 - External arm is a falling transition on the trigger input.
// RULE22 - Macro 0, if present, starts automatically after power-on completes.
// RULE23 - Macros are retained; a compressed macro becomes volatile. Reset here clears slot_valid, so no macro survives it.
// RULE24 - Enabled status bit set raises the service bit and asserts SRQ.
`timescale 1ns/1ps
module sbm_core
    import sbm_pkg::*;
#(
    parameter int MEM_BYTES = 14336
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic cmd_valid_i,
    input wire sbm_cmd_s cmd_i,
    input wire logic query_i,
    input wire logic clear_status_cmd_i,
    input wire logic service_mask_cmd_i,
    input wire logic [7:0] mask_i,
    input wire logic srq_cmd_i,
    input wire logic limit_i,
    input wire logic ready_i,
    input wire logic error_i,
    input wire logic data_avail_i,
    input wire logic power_on_done_i,
    input wire logic readings_done_i,
    input wire logic ext_trig_i,
    input wire logic [FREE_W-1:0] free_bytes_i,
    output logic [7:0] status_value_query_o,
    output logic query_valid_o,
    output logic srq_o,
    output logic exec_valid_o,
    output sbm_cmd_s exec_cmd_o,
    output logic hold_readings_o,
    output logic entry_refused_o,
    output logic [NUM_SLOTS-1:0] slot_volatile_o,
    output logic busy_o
);
    initial begin
        if (MEM_BYTES < MACRO_MIN_FREE) $error("MEM_BYTES too small");
    end

    // Macro store; not reset itself, but reset clears slot_valid, so stored macros are lost
    sbm_cmd_s mem [MEM_DEPTH];
    logic [PTR_W-1:0] slot_base [NUM_SLOTS];
    logic [LEN_W-1:0] slot_len [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] slot_valid, next_slot_valid;
    logic [NUM_SLOTS-1:0] next_slot_volatile;

    logic [7:0] status, next_status;
    logic [7:0] mask, next_mask;
    sbm_state_e state, next_state;
    logic [PTR_W-1:0] wr_ptr, next_wr_ptr;
    logic [PTR_W-1:0] pc, next_pc;
    logic [LEN_W-1:0] remain, next_remain;
    logic [LEN_W-1:0] entry_len, next_entry_len;
    logic [PTR_W-1:0] entry_base, next_entry_base;
    logic [SLOT_W-1:0] entry_slot, next_entry_slot;
    logic autostart_done, next_autostart_done;
    logic ext_prev;
    logic [7:0] query_val, next_query_val;
    logic query_valid, next_query_valid;
    logic exec_valid, next_exec_valid;
    sbm_cmd_s exec_cmd, next_exec_cmd;
    logic refused, next_refused;
    logic mem_we, slot_commit;

    logic ext_fall, cmd_run;
    sbm_cmd_s cur;
    logic [7:0] cause;

    assign ext_fall = ext_prev && !ext_trig_i; // RULE20 RULE21
    assign cur = mem[pc];
    assign cmd_run = (state == ST_RUN) && remain != '0;
    assign cause = {data_avail_i, 1'b0, error_i, ready_i, 1'b0, srq_cmd_i, limit_i, 1'b0};

    // Status byte and service request
    always_comb begin
        logic [7:0] keep;
        keep = '0;
        next_status = status | cause; // RULE5 RULE2 RULE3
        next_mask = mask;
        if (service_mask_cmd_i) begin
            next_mask = mask_i; // RULE8
        end
        if (clear_status_cmd_i) begin
            // Sticky causes still present survive the clear
            keep[BIT_READY] = ready_i;
            keep[BIT_ERROR] = error_i;
            keep[BIT_SERVICE] = |(status & mask & 8'hbf & cause);
            next_status = cause | keep; // RULE7
        end
        if (cmd_run && cur.op == CMD_END_MACRO) begin
            next_status[BIT_MACRO_DONE] = 1'b1; // RULE2
        end
        if (power_on_done_i && !autostart_done) begin
            next_status[BIT_POWER_ON] = 1'b1;
        end
        if (|(next_status & next_mask & 8'hbf)) begin
            next_status[BIT_SERVICE] = 1'b1; // RULE24 RULE4
        end
        next_query_valid = query_i;
        next_query_val = query_i ? (status & 8'hef) : query_val; // RULE1 RULE6
    end

    // Macro entry and execution
    always_comb begin
        next_state = state;
        next_wr_ptr = wr_ptr;
        next_pc = pc;
        next_remain = remain;
        next_entry_len = entry_len;
        next_entry_base = entry_base;
        next_entry_slot = entry_slot;
        next_autostart_done = autostart_done;
        next_exec_valid = 1'b0;
        next_exec_cmd = exec_cmd;
        next_refused = 1'b0;
        next_slot_valid = slot_valid;
        next_slot_volatile = slot_volatile_o;
        mem_we = 1'b0;
        slot_commit = 1'b0;
        case (state)
            ST_IDLE: begin
                if (power_on_done_i && !autostart_done) begin
                    next_autostart_done = 1'b1;
                    if (slot_valid[0]) begin // RULE22
                        next_pc = slot_base[0];
                        next_remain = slot_len[0];
                        next_state = ST_RUN;
                    end
                end else if (cmd_valid_i) begin
                    case (cmd_i.op)
                        CMD_BEGIN_MACRO: begin
                            if (free_bytes_i < FREE_W'(MACRO_MIN_FREE)) begin
                                next_refused = 1'b1; // RULE15
                            end else begin
                                next_entry_slot = cmd_i.slot; // RULE10
                                next_entry_base = wr_ptr;
                                next_entry_len = '0;
                                next_state = ST_ENTRY;
                            end
                        end
                        CMD_INVOKE: begin
                            if (slot_valid[cmd_i.slot]) begin // RULE11
                                next_pc = slot_base[cmd_i.slot];
                                next_remain = slot_len[cmd_i.slot];
                                next_state = ST_RUN;
                            end
                        end
                        CMD_DELETE_MACRO: next_slot_valid[cmd_i.slot] = 1'b0;
                        CMD_ERASE_ALL: begin
                            next_slot_valid = '0;
                            next_wr_ptr = '0;
                        end
                        CMD_COMPRESS: next_slot_volatile[cmd_i.slot] = 1'b1; // RULE23
                        default: ;
                    endcase
                end
            end
            ST_ENTRY: begin
                if (cmd_valid_i) begin
                    case (cmd_i.op)
                        CMD_END_MACRO: begin
                            mem_we = 1'b1;
                            next_wr_ptr = wr_ptr + 1'b1;
                            slot_commit = 1'b1; // RULE12 RULE11
                            next_slot_valid[entry_slot] = 1'b1;
                            next_slot_volatile[entry_slot] = 1'b0;
                            next_state = ST_IDLE;
                        end
                        CMD_DEVICE_CLEAR: begin
                            next_wr_ptr = entry_base; // RULE17
                            next_state = ST_IDLE;
                        end
                        CMD_ERASE_ALL, CMD_DELETE_MACRO, CMD_BEGIN_MACRO: ; // RULE13
                        default: begin
                            mem_we = 1'b1;
                            next_wr_ptr = wr_ptr + 1'b1;
                            next_entry_len = entry_len + 1'b1;
                        end
                    endcase
                end
            end
            ST_RUN: begin
                if (remain == '0) begin
                    next_state = ST_IDLE;
                end else begin
                    next_pc = pc + 1'b1;
                    next_remain = remain - 1'b1;
                    case (cur.op)
                        CMD_RESET: next_state = ST_IDLE; // RULE14
                        CMD_END_MACRO: next_state = ST_IDLE;
                        CMD_SINGLE_SHOT: begin
                            next_exec_valid = 1'b1;
                            next_exec_cmd = cur;
                            next_state = ST_WAIT_SHOT; // RULE18
                        end
                        CMD_ARM_EXT: next_state = ST_WAIT_EXT; // RULE20
                        default: begin
                            next_exec_valid = 1'b1; // RULE19
                            next_exec_cmd = cur;
                        end
                    endcase
                end
            end
            ST_PAUSED: ;
            ST_WAIT_SHOT: begin
                if (readings_done_i) begin
                    next_state = ST_RUN; // RULE18
                end
            end
            ST_WAIT_EXT: begin
                if (ext_fall) begin
                    next_state = ST_RUN; // RULE20
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // Aborts win over pause and resume, so a pause never masks an error
        if (state != ST_IDLE && state != ST_ENTRY) begin
            if (error_i || (cmd_valid_i && cmd_i.op == CMD_DEVICE_CLEAR)) begin
                next_state = ST_IDLE; // RULE16 RULE17
                next_exec_valid = 1'b0;
            end else if (cmd_valid_i && cmd_i.op == CMD_PAUSE && state == ST_RUN
                         && next_state != ST_IDLE) begin
                next_state = ST_PAUSED; // RULE11
            end else if (cmd_valid_i && cmd_i.op == CMD_RESUME && state == ST_PAUSED) begin
                next_state = ST_RUN; // RULE11
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            status <= STATUS_RESET;
            mask <= MASK_RESET;
            state <= ST_IDLE;
            wr_ptr <= '0;
            pc <= '0;
            remain <= '0;
            entry_len <= '0;
            entry_base <= '0;
            entry_slot <= '0;
            autostart_done <= 1'b0;
            ext_prev <= 1'b1;
            query_val <= '0;
            query_valid <= 1'b0;
            exec_valid <= 1'b0;
            exec_cmd <= '0;
            refused <= 1'b0;
            slot_valid <= '0;
            slot_volatile_o <= '0;
        end else begin
            status <= next_status;
            mask <= next_mask;
            state <= next_state;
            wr_ptr <= next_wr_ptr;
            pc <= next_pc;
            remain <= next_remain;
            entry_len <= next_entry_len;
            entry_base <= next_entry_base;
            entry_slot <= next_entry_slot;
            autostart_done <= next_autostart_done;
            ext_prev <= ext_trig_i;
            query_val <= next_query_val;
            query_valid <= next_query_valid;
            exec_valid <= next_exec_valid;
            exec_cmd <= next_exec_cmd;
            refused <= next_refused;
            slot_valid <= next_slot_valid;
            slot_volatile_o <= next_slot_volatile;
        end
    end

    // Store arrays are not reset; slot_valid guards them
    always_ff @(posedge mclk_i) begin
        if (mem_we) begin
            mem[wr_ptr] <= cmd_i;
        end
        if (slot_commit) begin
            slot_base[entry_slot] <= entry_base;
            slot_len[entry_slot] <= entry_len + 1'b1;
        end
    end

    assign status_value_query_o = query_val;
    assign query_valid_o = query_valid;
    assign srq_o = status[BIT_SERVICE]; // RULE24
    assign exec_valid_o = exec_valid;
    assign exec_cmd_o = exec_cmd;
    assign hold_readings_o = state != ST_IDLE && state != ST_ENTRY; // RULE19
    assign entry_refused_o = refused;
    assign busy_o = state != ST_IDLE;

    a_query_ready_clear: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE6
        query_i |=> !status_value_query_o[BIT_READY] && query_valid_o)
        else $error("ready bit set in query answer");
    a_service_unmaskable: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE24
        (|(cause & mask & 8'hbf) && !service_mask_cmd_i) |=> srq_o)
        else $error("enabled condition without service request");
    a_entry_refused: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE15
        (state == ST_IDLE && cmd_valid_i && cmd_i.op == CMD_BEGIN_MACRO
         && free_bytes_i < FREE_W'(MACRO_MIN_FREE) && !(power_on_done_i && !autostart_done))
        |=> entry_refused_o && state == ST_IDLE)
        else $error("entry not refused on low memory");
    a_clear_aborts: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE17
        (cmd_valid_i && cmd_i.op == CMD_DEVICE_CLEAR && state != ST_IDLE) |=> !busy_o)
        else $error("device clear did not abort");
    a_error_aborts: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE16
        (error_i && state inside {ST_RUN, ST_PAUSED, ST_WAIT_SHOT, ST_WAIT_EXT}) |=> !busy_o)
        else $error("error did not abort macro");
    a_shot_stall: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE18
        (state == ST_WAIT_SHOT && !readings_done_i) |=> $stable(pc))
        else $error("macro advanced before readings done");
    a_ext_wait: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE20
        (state == ST_WAIT_EXT && !ext_fall && !error_i && !cmd_valid_i)
        |=> state == ST_WAIT_EXT)
        else $error("external wait left without edge");
    a_reset_aborts: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE14
        (cmd_run && cur.op == CMD_RESET) |=> !busy_o)
        else $error("reset in macro did not abort");
    a_done_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE2
        (cmd_run && !error_i && cur.op == CMD_END_MACRO && !clear_status_cmd_i)
        |=> status[BIT_MACRO_DONE])
        else $error("completion bit not set");
endmodule

// ---- verification/sbm_host_model.sv ----
// Host controller model issuing parsed commands and status requests
`timescale 1ns/1ps
module sbm_host_model
    import sbm_pkg::*;
(
    input wire logic mclk_i,
    input wire logic query_valid_i,
    input wire logic [7:0] status_i,
    output logic cmd_valid_o,
    output sbm_cmd_s cmd_o,
    output logic query_o,
    output logic clear_o,
    output logic mask_cmd_o,
    output logic [7:0] mask_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
        {query_o, clear_o, mask_cmd_o} = 3'h0;
        mask_o = 8'h00;
    end
    // Integer names only; the parser folds bare and prefixed forms to a slot
    task automatic send(input sbm_cmd_e op, input logic [6:0] slot, input logic [11:0] arg);
        @(posedge mclk_i);
        #1;
        cmd_o = '{op: op, slot: slot, arg: arg};
        cmd_valid_o = 1'b1;
        @(posedge mclk_i);
        #1;
        cmd_valid_o = 1'b0;
        // Released bus shows junk, not the last value
        cmd_o = sbm_cmd_s'(~cmd_o);
    endtask
    task automatic pulse(input int kind, input logic [7:0] m);
        @(posedge mclk_i);
        #1;
        mask_o = m;
        {query_o, clear_o, mask_cmd_o} = {kind == 0, kind == 1, kind == 2};
        @(posedge mclk_i);
        #1;
        {query_o, clear_o, mask_cmd_o} = 3'h0;
        mask_o = ~m;
    endtask
    task automatic query(output logic [7:0] v);
        pulse(0, 8'h00);
        for (int i = 0; i < 4 && query_valid_i !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
        end
        v = (query_valid_i === 1'b1) ? status_i : 8'hxx;
    endtask
endmodule

// ---- verification/status_byte_and_macro_runner_test.sv ----
// Self-checking bench for the status byte and macro runner
`timescale 1ns/1ps
module status_byte_and_macro_runner_test;
    import sbm_pkg::*;
    typedef struct packed {logic [7:0] cond; logic [7:0] msk; logic [7:0] exp;} sbm_row_s;
    localparam sbm_row_s ROWS [6] = '{'{8'h02, 8'h00, 8'h02}, '{8'h02, 8'h02, 8'h42},
        '{8'h84, 8'h80, 8'hc4}, '{8'h10, 8'h10, 8'h40}, '{8'h20, 8'h40, 8'h20},
        '{8'hb6, 8'hff, 8'he6}};
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cv, qry, clr, mcmd, qv, srq, ev, hold, refused, busy;
    logic [7:0] mask, stv, v;
    logic srq_c = 1'b0, limit = 1'b0, ready = 1'b0, err = 1'b0, data = 1'b0;
    logic pod = 1'b0, rdone = 1'b0, ext = 1'b1;
    logic [FREE_W-1:0] free = 16'h1000;
    sbm_cmd_s cmd, ecmd;
    logic [NUM_SLOTS-1:0] vol;
    int failures = 0;
    int compares = 0;
    int execs = 0;
    logic [11:0] args [$];
    always #2.5 mclk_i = ~mclk_i;
    sbm_core u_sbm_core (.mclk_i(mclk_i), .resetn_i(resetn_i), .cmd_valid_i(cv), .cmd_i(cmd),
        .query_i(qry), .clear_status_cmd_i(clr), .service_mask_cmd_i(mcmd), .mask_i(mask),
        .srq_cmd_i(srq_c), .limit_i(limit), .ready_i(ready), .error_i(err),
        .data_avail_i(data), .power_on_done_i(pod), .readings_done_i(rdone),
        .ext_trig_i(ext), .free_bytes_i(free), .status_value_query_o(stv),
        .query_valid_o(qv), .srq_o(srq), .exec_valid_o(ev), .exec_cmd_o(ecmd),
        .hold_readings_o(hold), .entry_refused_o(refused), .slot_volatile_o(vol),
        .busy_o(busy));
    sbm_host_model u_sbm_host_model (.mclk_i(mclk_i), .query_valid_i(qv), .status_i(stv),
        .cmd_valid_o(cv), .cmd_o(cmd), .query_o(qry), .clear_o(clr), .mask_cmd_o(mcmd),
        .mask_o(mask));
    always @(posedge mclk_i) begin
        if (ev === 1'b1) begin
            execs++;
            args.push_back(ecmd.arg);
        end
    end
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic put(input sbm_cmd_e op, input int s);
        u_sbm_host_model.send(op, 7'(s), 12'h000);
    endtask
    task automatic conds(input logic [7:0] c);
        {data, err, ready, srq_c, limit} = {c[7], c[5], c[4], c[2], c[1]};
    endtask
    // Stored argument is the list index plus base, so runs can be traced
    task automatic mac(input int s, input sbm_cmd_e ops [$], input logic [11:0] b);
        put(CMD_BEGIN_MACRO, s);
        foreach (ops[i]) u_sbm_host_model.send(ops[i], 7'(s), b + 12'(i));
        put(CMD_END_MACRO, s);
    endtask
    task automatic run(input int s);
        execs = 0;
        args.delete();
        put(CMD_INVOKE, s);
    endtask
    task automatic wait_idle();
        tick(2);
        for (int i = 0; i < 60 && busy !== 1'b0; i++) tick(1);
    endtask
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
    initial begin
        tick(16);
        resetn_i = 1'b1;
        chk("rst", 0, {srq, busy, refused, ev, qv, |vol});
        u_sbm_host_model.query(v);
        chk("rst query", 8'h00, v);
        mac(0, '{CMD_OTHER, CMD_OTHER}, 12'h010);
        pod = 1'b1;
        wait_idle();
        chk("auto n", 2, execs);
        chk("auto arg", 12'h011, args[1]);
        u_sbm_host_model.query(v);
        chk("power done", 8'h09, v);
        $display("test power-on done");
        foreach (ROWS[i]) begin
            conds(8'h00);
            u_sbm_host_model.pulse(1, 8'h00);
            u_sbm_host_model.pulse(2, ROWS[i].msk);
            conds(ROWS[i].cond);
            tick(1);
            conds(8'h00);
            tick(3);
            u_sbm_host_model.query(v);
            chk("row query", ROWS[i].exp, v);
            chk("row srq", ROWS[i].exp[6], srq);
        end
        $display("test table done");
        conds(8'h30);
        u_sbm_host_model.pulse(2, 8'h10);
        tick(3);
        u_sbm_host_model.pulse(1, 8'h00);
        tick(3);
        u_sbm_host_model.query(v);
        chk("clear kept", 8'h60, v);
        conds(8'h00);
        u_sbm_host_model.pulse(1, 8'h00);
        tick(3);
        u_sbm_host_model.query(v);
        chk("clear all", 8'h00, v);
        chk("clear srq", 0, srq);
        $display("test clear done");
        free = 16'h031f;
        put(CMD_BEGIN_MACRO, 3);
        chk("refuse", 2'b10, {refused, busy});
        free = 16'h0320;
        put(CMD_BEGIN_MACRO, 3);
        chk("accept", 2'b01, {refused, busy});
        put(CMD_END_MACRO, 3);
        mac(5, '{CMD_OTHER, CMD_ERASE_ALL, CMD_DELETE_MACRO, CMD_BEGIN_MACRO, CMD_OTHER}, 12'h001);
        run(5);
        wait_idle();
        chk("discard n", 2, execs);
        chk("discard arg", 12'h005, args[1]);
        mac(5, '{CMD_OTHER}, 12'h070);
        run(5);
        wait_idle();
        chk("replace", {32'(1), 12'h070}, {execs, args[0]});
        put(CMD_COMPRESS, 5);
        tick(1);
        chk("volatile", 32'h20, vol[31:0]);
        put(CMD_DELETE_MACRO, 5);
        run(5);
        tick(3);
        chk("deleted", 0, {execs, busy});
        $display("test store done");
        mac(6, '{CMD_ARM_OTHER, CMD_SINGLE_SHOT, CMD_OTHER}, 12'h030);
        run(6);
        tick(12);
        chk("shot wait", {32'(2), 2'b11}, {execs, busy, hold});
        rdone = 1'b1;
        tick(1);
        rdone = 1'b0;
        wait_idle();
        chk("shot go", {32'(3), 12'h032, 1'b0}, {execs, args[2], hold});
        ext = 1'b0;
        mac(7, '{CMD_ARM_EXT, CMD_OTHER}, 12'h040);
        run(7);
        tick(5);
        ext = 1'b1;
        tick(5);
        chk("ext rise", {32'(0), 1'b1}, {execs, busy});
        ext = 1'b0;
        wait_idle();
        chk("ext fall", {32'(1), 12'h041}, {execs, args[0]});
        run(7);
        tick(5);
        err = 1'b1;
        tick(1);
        err = 1'b0;
        tick(3);
        chk("err abort", {32'(0), 1'b0}, {execs, busy});
        run(7);
        tick(3);
        put(CMD_DEVICE_CLEAR, 0);
        tick(2);
        chk("clr run", 0, busy);
        put(CMD_BEGIN_MACRO, 9);
        put(CMD_DEVICE_CLEAR, 0);
        tick(1);
        chk("clr entry", 0, busy);
        mac(8, '{CMD_OTHER, CMD_RESET, CMD_OTHER}, 12'h050);
        run(8);
        wait_idle();
        chk("reset abort", 1, execs);
        $display("test abort done");
        mac(10, '{8{CMD_OTHER}}, 12'h060);
        run(10);
        put(CMD_PAUSE, 10);
        tick(2);
        v = 8'(execs);
        tick(10);
        chk("paused", {v, 1'b1}, {8'(execs), busy});
        put(CMD_RESUME, 10);
        wait_idle();
        chk("resumed", 8, execs);
        $display("test pause done");
        run(10);
        tick(2);
        resetn_i = 1'b0;
        tick(2);
        resetn_i = 1'b1;
        u_sbm_host_model.query(v);
        chk("mid rst", {8'h08, 1'b0}, {v, busy});
        $display("test reset done");
        give_verdict();
    end
endmodule
